// File: bench/csw_chk_properties.sv
`timescale 1ns/100ps
// ****
// bus, fail and power-save checks
// ****
module csw_chk (
  input wire logic aclk, aresetn,
  input wire logic awvalid, awready, wvalid, wready, bvalid,
  input wire logic psv_req, psv_mode, cpu_halt, idle_mode,
  input wire logic sleep_mode, periph_clk_en, wdt_clear, wdt_en,
  input wire logic clk_fail_trap,
  input wire logic [2:0] sys_sel,
  input wire csw_pkg::csw_osc_en_t osc_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_resume;
    cpu_halt [*3] ##1 !cpu_halt;
  endsequence
  chk_wr_resp:
  assert property (awvalid && awready && wvalid && wready |-> ##3 bvalid)
    else $error("write answer late");
  chk_fail_target:
  assert property (clk_fail_trap |->
    sys_sel == {2'h0, $past(sys_sel) == csw_pkg::SRC_PRI_PLL})
    else $error("fail source wrong");
  chk_trap_pulse:
  assert property (clk_fail_trap |=> !clk_fail_trap)
    else $error("trap too long");
  chk_idle_entry:
  assert property (psv_req && !cpu_halt && psv_mode |=>
    idle_mode && cpu_halt && wdt_clear) else $error("idle entry");
  chk_sleep_entry:
  assert property (psv_req && !cpu_halt && !psv_mode |=>
    sleep_mode && cpu_halt && wdt_clear == $past(wdt_en))
    else $error("sleep entry");
  chk_sleep_perif:
  assert property (sleep_mode |-> !periph_clk_en) else $error("perif on");
  chk_idle_resume:
  assert property ($fell(idle_mode) |-> s_resume) else $error("resume");
  chk_sleep_osc:
  assert property (sleep_mode && $past(sleep_mode) |->
    osc_en == {3'h0, wdt_en, 1'b0}) else $error("sleep osc");
endmodule
bind csw_clock_ctrl csw_chk i_csw_chk (.*);

// File: bench/csw_osc_model.sv
`timescale 1ns/100ps
// ****
// oscillators, start-up timer, pll
// ****
module csw_osc_model #(parameter int DLY = 5) (
  input  wire logic aclk,
  input  wire csw_pkg::csw_osc_en_t osc_en,
  output logic ost_expired,
  output logic pll_locked,
  output logic new_clk_tick
);
  int ost_c = 0;
  int pll_c = 0;
  initial new_clk_tick = 1'b0;
  // ready drops with the enable, so restarts are slow
  always @(posedge aclk) begin
    ost_c <= (osc_en.pri | osc_en.sec) ? ost_c + 1 : 0;
    pll_c <= osc_en.pll ? pll_c + 1 : 0;
    new_clk_tick <= ~new_clk_tick;
  end
  assign ost_expired = ost_c > DLY;
  assign pll_locked = pll_c > 2 * DLY;
endmodule

// File: bench/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, unlock_hi = 0, unlock_lo = 0;
  logic osc_fail = 0, wdt_en = 1, psv_req = 0, psv_mode = 0;
  logic wake_irq = 0, wdt_timeout = 0, ost_expired, pll_locked;
  logic new_clk_tick, awready, wready, bvalid, arready, rvalid;
  logic clk_fail_trap, wdt_clear, cpu_halt, periph_clk_en;
  logic sleep_mode, idle_mode;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rd_v;
  logic [1:0] bresp, rresp, pri_submode, rs_v, bs_v;
  logic [2:0] sys_sel;
  csw_pkg::csw_cfg_t cfg_in = 7'h01;
  csw_pkg::csw_osc_en_t osc_en;
  int n_fail = 0, cmp_count = 0;
  // {new select, expected source}; no pll-to-pll hop
  logic [5:0] rows [10] = '{6'h12, 6'h1b, 6'h00, 6'h09, 6'h24,
                            6'h2d, 6'h36, 6'h3f, 6'h1b, 6'h1b};
  csw_clock_ctrl i_csw_clock_ctrl (.*);
  csw_osc_model i_csw_osc_model (.*);
  always #20 aclk = ~aclk;
  task chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bs_v = bresp; bready <= 0;
    @(posedge aclk);
  endtask
  task rd(input logic [3:0] a);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rd_v = rdata; rs_v = rresp; rready <= 0;
    @(posedge aclk);
  endtask
  task unl(input logic hi);
    unlock_hi <= hi; unlock_lo <= !hi;
    @(posedge aclk);
    unlock_hi <= 0; unlock_lo <= 0;
  endtask
  task sw(input logic [2:0] c);
    unl(1); wr(4'h0, {21'h0, c, 8'h00}, 4'h2);
    unl(0); wr(4'h0, 32'h1, 4'h1);
    repeat (60) begin
      rd(4'h0);
      if (rd_v[0] === 1'b0) break;
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1; repeat (2) @(posedge aclk);
    chk("submode", 32'h1, {30'h0, pri_submode});
    for (int i = 0; i < 10; i++) begin
      sw(rows[i][5:3]);
      chk("src", {29'h0, rows[i][2:0]}, {29'h0, sys_sel});
      chk("cur", {29'h0, rows[i][2:0]}, {29'h0, rd_v[14:12]});
    end
    // byte1 write without permit leaves new equal to current
    wr(4'h0, 32'h200, 4'h2); unl(0); wr(4'h0, 32'h1, 4'h1); rd(4'h0);
    chk("permit", 32'h3, {29'h0, sys_sel});
    chk("abort", 32'h0, {31'h0, rd_v[0]});
    osc_fail <= 1; @(posedge aclk); osc_fail <= 0; #1;
    chk("trap", 32'h1, {31'h0, clk_fail_trap});
    chk("fail_src", 32'h1, {29'h0, sys_sel});
    @(posedge aclk); rd(4'h0);
    chk("cf_set", 32'h1, {31'h0, rd_v[3]});
    unl(0); wr(4'h0, 32'h0, 4'h1); rd(4'h0);
    chk("cf_clr", 32'h0, {31'h0, rd_v[3]});
    for (int m = 1; m >= 0; m--) begin
      psv_mode <= m[0]; psv_req <= 1; @(posedge aclk); psv_req <= 0; #1;
      chk("halt", 32'h1, {31'h0, cpu_halt});
      chk("perif", {31'h0, m[0]}, {31'h0, periph_clk_en});
      repeat (3) @(posedge aclk);
      wake_irq <= m[0]; wdt_timeout <= !m[0]; @(posedge aclk);
      wake_irq <= 0; wdt_timeout <= 0; repeat (6) @(posedge aclk); #1;
      chk("wake", 32'h0, {31'h0, cpu_halt});
      chk("same_src", 32'h1, {29'h0, sys_sel});
      @(posedge aclk);
    end
    // switching off, power-on source low_power_rc_osc
    cfg_in <= 7'h75; aresetn <= 0; repeat (6) @(posedge aclk);
    aresetn <= 1; repeat (2) @(posedge aclk); sw(3'h2);
    chk("sw_off", 32'h5, {29'h0, sys_sel});
    chk("req_zero", 32'h0, {31'h0, rd_v[0]});
    rd(4'h4);
    chk("resp", {30'h0, csw_pkg::RESP_SLVERR}, {30'h0, rs_v});
    wr(4'h4, 32'h0, 4'hf);
    chk("bresp", {30'h0, csw_pkg::RESP_SLVERR}, {30'h0, bs_v});
    // switch-only mode with the lock set refuses the request
    cfg_in <= 7'h21; aresetn <= 0; repeat (6) @(posedge aclk);
    aresetn <= 1; repeat (2) @(posedge aclk);
    unl(0); wr(4'h0, 32'h80, 4'h1); sw(3'h5);
    chk("lock", 32'h0, {29'h0, sys_sel});
    chk("lock_req", 32'h0, {31'h0, rd_v[0]});
    stop_test;
  end
  initial begin
    repeat (8000) @(posedge aclk);
    n_fail++;
    stop_test;
  end
endmodule

// File: logic/csw_axil.sv
`timescale 1ns/100ps
module csw_axil (
  // clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // write channels
  input  wire logic [csw_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  // read channels
  input  wire logic [csw_pkg::ADDR_W-1:0] araddr,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready,
  // register side
  output logic                          wr_en,
  output logic [csw_pkg::ADDR_W-1:0]    wr_addr,
  output logic [31:0]                   wr_data,
  output logic [3:0]                    wr_strb,
  input  wire logic                     wr_ok,
  output logic [csw_pkg::ADDR_W-1:0]    rd_addr,
  input  wire logic [31:0]              rd_data,
  input  wire logic                     rd_ok
);

  logic aw_have;
  logic w_have;
  logic rd_en;

  // ****************************************
  // write path
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      wr_en   <= 1'b0;
      wr_addr <= '0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= csw_pkg::RESP_OKAY;
    end else begin
      wr_en <= 1'b0;
      if (awvalid && awready) begin
        wr_addr <= awaddr;
        aw_have <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wr_data <= wdata;
        wr_strb <= wstrb;
        w_have  <= 1'b1;
        wready  <= 1'b0;
      end
      if (aw_have && w_have && !bvalid && !wr_en) begin
        wr_en <= 1'b1;
      end
      if (wr_en) begin
        bvalid  <= 1'b1;
        bresp   <= wr_ok ? csw_pkg::RESP_OKAY : csw_pkg::RESP_SLVERR;
        aw_have <= 1'b0;
        w_have  <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rd_en   <= 1'b0;
      rd_addr <= '0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= csw_pkg::RESP_OKAY;
    end else begin
      rd_en <= 1'b0;
      if (arvalid && arready) begin
        rd_addr <= araddr;
        arready <= 1'b0;
        rd_en   <= 1'b1;
      end
      if (rd_en) begin
        rvalid <= 1'b1;
        rdata  <= rd_data;
        rresp  <= rd_ok ? csw_pkg::RESP_OKAY : csw_pkg::RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule

// File: logic/csw_clock_ctrl.sv
// Summary of operation
// - switching allowed only when switch-mode config bit is zero
// - disabled: new select ignored, current field shows power-on config
// - disabled: switch request has no effect, always reads zero
// - request with new equal to current clears request, aborts
// - valid switch start clears pll lock and clock fail bits
// - power new oscillator, wait start-up timer and pll lock
// - count ten new-clock cycles before changing system clock
// - completion clears request and copies new select to current
// - old source off except low_power_rc_osc for watchdog/monitor, secondary enabled
// - processor keeps running during the whole switch
// - primary submode fixed by configuration, never by software
// - monitor enabled keeps low_power_rc_osc running except in sleep
// - failure raises trap, moves to fast rc, keeping pll if used
// - power-save request selects sleep or idle
// - sleep stops clocks, oscillators, monitor and peripheral clock
// - sleep clears watchdog first, low_power_rc_osc runs if watchdog enabled
// - wake on enabled interrupt, reset or watchdog time-out
// - sleep wake resumes on the same clock source
// - idle clears watchdog, keeps system clock and low_power_rc_osc as needed
// - idle wake reapplies cpu clock a few cycles later
// - three-bit source codes 000 through 111 as listed
// - clock lock blocks switching when switching on, monitor off
// - clock fail flag reads one after failure, software clears it
// - control writes rejected without a preceding unlock
`timescale 1ns/100ps
module csw_clock_ctrl (
  // clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // axi4-lite write
  input  wire logic [csw_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  // axi4-lite read
  input  wire logic [csw_pkg::ADDR_W-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  // configuration straps and unlock
  input  wire csw_pkg::csw_cfg_t          cfg_in,
  input  wire logic                       unlock_hi,
  input  wire logic                       unlock_lo,
  // oscillator side
  input  wire logic                       ost_expired,
  input  wire logic                       pll_locked,
  input  wire logic                       new_clk_tick,
  input  wire logic                       osc_fail,
  output csw_pkg::csw_osc_en_t            osc_en,
  output logic [2:0]                      sys_sel,
  output logic [1:0]                      pri_submode,
  output logic                            clk_fail_trap,
  // core and watchdog side
  input  wire logic                       wdt_en,
  input  wire logic                       psv_req,
  input  wire logic                       psv_mode,
  input  wire logic                       wake_irq,
  input  wire logic                       wdt_timeout,
  output logic                            wdt_clear,
  output logic                            cpu_halt,
  output logic                            periph_clk_en,
  output logic                            sleep_mode,
  output logic                            idle_mode
);

  // ****************************************
  // declarations
  // ****************************************
  csw_pkg::csw_cfg_t       cfg_q;
  logic                    strap_done;
  logic [2:0]              cur_src;
  logic [2:0]              new_src;
  logic [2:0]              tgt_src;
  logic                    clk_lock;
  logic                    pll_lock_st;
  logic                    cf;
  logic                    sec_en;
  logic                    sw_req;
  logic                    permit_hi;
  logic                    permit_lo;
  csw_pkg::csw_sw_state_t  sw_state;
  csw_pkg::csw_pm_state_t  pm_state;
  logic                    wr_en;
  logic [csw_pkg::ADDR_W-1:0] wr_addr;
  logic [31:0]             wr_data;
  logic [3:0]              wr_strb;
  logic [csw_pkg::ADDR_W-1:0] rd_addr;
  logic [31:0]             rd_data;
  logic                    rd_ok;
  logic                    wr_ok;
  logic                    wr_hit;
  logic                    hi_ok;
  logic                    lo_ok;
  logic                    sw_en;
  logic                    fsm_en;
  logic                    sw_blocked;
  logic                    sw_start;
  logic                    src_ready;
  logic                    cnt_start;
  logic                    cnt_done;
  logic                    fail_evt;
  logic                    wake_evt;
  logic                    res_done;
  csw_pkg::csw_osc_en_t    next_osc_en;
  csw_pkg::csw_osc_en_t    cur_osc;
  csw_pkg::csw_osc_en_t    tgt_osc;

  // ****************************************
  // helpers
  // ****************************************
  function automatic csw_pkg::csw_osc_en_t src_osc(input logic [2:0] s);
    csw_pkg::csw_osc_en_t e;
    e = '0;
    unique case (s)
      csw_pkg::SRC_FRC, csw_pkg::SRC_FRC_D16,
      csw_pkg::SRC_FRC_DIVN: e.fast_rc_osc = 1'b1;
      csw_pkg::SRC_FRC_PLL: begin
        e.fast_rc_osc = 1'b1;
        e.pll = 1'b1;
      end
      csw_pkg::SRC_PRI: e.pri = 1'b1;
      csw_pkg::SRC_PRI_PLL: begin
        e.pri = 1'b1;
        e.pll = 1'b1;
      end
      csw_pkg::SRC_SEC: e.sec = 1'b1;
      csw_pkg::SRC_LOW_POWER_RC_OSC: e.low_power_rc_osc = 1'b1;
    endcase
    return e;
  endfunction

  // ****************************************
  // bus slave
  // ****************************************
  csw_axil u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  assign wr_ok  = (wr_addr == csw_pkg::OSC_CTRL_ADDR);
  assign rd_ok  = (rd_addr == csw_pkg::OSC_CTRL_ADDR);
  assign wr_hit = wr_en && wr_ok;
  assign hi_ok  = wr_hit && wr_strb[1] && permit_hi;
  assign lo_ok  = wr_hit && wr_strb[0] && permit_lo;

  always_comb begin
    rd_data = 32'h0;
    if (rd_ok) begin
      rd_data[csw_pkg::CUR_LSB +: 3] = cur_src;
      rd_data[csw_pkg::NEW_LSB +: 3] = new_src;
      rd_data[csw_pkg::LOCK_BIT]     = clk_lock;
      rd_data[csw_pkg::PLL_BIT]      = pll_lock_st;
      rd_data[csw_pkg::CF_BIT]       = cf;
      rd_data[csw_pkg::SEC_BIT]      = sec_en;
      rd_data[csw_pkg::SWREQ_BIT]    = sw_req;
    end
  end

  // ****************************************
  // straps, caught after reset release
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q      <= '1;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      cfg_q      <= cfg_in;
      strap_done <= 1'b1;
    end
  end

  assign sw_en  = strap_done && !cfg_q.switch_mode_cfg_field[1];
  assign fsm_en = strap_done &&
                  (cfg_q.switch_mode_cfg_field == csw_pkg::CKSM_ALL);
  assign sw_blocked = clk_lock &&
    (cfg_q.switch_mode_cfg_field == csw_pkg::CKSM_SW_ONLY);
  // submode never reaches the register file
  assign pri_submode = cfg_q.primary_submode_cfg;

  // ****************************************
  // unlock permits, one write each
  // ****************************************
  // an unlock in the same cycle as a write survives for the next one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      permit_hi <= 1'b0;
      permit_lo <= 1'b0;
    end else begin
      permit_hi <= unlock_hi || (permit_hi && !wr_en);
      permit_lo <= unlock_lo || (permit_lo && !wr_en);
    end
  end

  // ****************************************
  // software fields
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      new_src  <= csw_pkg::SRC_FRC;
      clk_lock <= 1'b0;
      sec_en   <= 1'b0;
    end else if (!strap_done) begin
      new_src  <= cfg_in.poweron_source_cfg;
    end else begin
      if (hi_ok) begin
        new_src <= wr_data[csw_pkg::NEW_LSB +: 3];
      end
      if (lo_ok) begin
        clk_lock <= wr_data[csw_pkg::LOCK_BIT];
        sec_en   <= wr_data[csw_pkg::SEC_BIT];
      end
    end
  end

  // ****************************************
  // switch sequencer
  // ****************************************
  assign cur_osc   = src_osc(cur_src);
  assign tgt_osc   = src_osc(tgt_src);
  assign sw_start  = (sw_state == csw_pkg::SW_IDLE) && sw_req &&
                     (new_src != cur_src) && !fail_evt;
  // secondary and crystal primaries need the start-up timer
  assign src_ready =
    (!(tgt_osc.sec ||
       (tgt_osc.pri &&
        cfg_q.primary_submode_cfg != csw_pkg::SUB_EC)) ||
     ost_expired) &&
    (!tgt_osc.pll || pll_locked);
  assign cnt_start = (sw_state == csw_pkg::SW_WAIT) && src_ready &&
                     !fail_evt;
  assign fail_evt  = osc_fail && fsm_en && (pm_state != csw_pkg::PM_SLEEP) &&
                     !cur_osc.fast_rc_osc;

  csw_tick_cnt #(
    .W (csw_pkg::CNT_W),
    .N (csw_pkg::NEW_CLK_WAIT)
  ) u_switch_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (cnt_start),
    .tick    (new_clk_tick),
    .busy    (),
    .done    (cnt_done)
  );

  // cpu_halt is never touched here, code runs on throughout
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_state <= csw_pkg::SW_IDLE;
      cur_src  <= csw_pkg::SRC_FRC;
      tgt_src  <= csw_pkg::SRC_FRC;
      sw_req   <= 1'b0;
    end else if (!strap_done) begin
      cur_src  <= cfg_in.poweron_source_cfg;
    end else if (fail_evt) begin
      sw_state <= csw_pkg::SW_IDLE;
      sw_req   <= 1'b0;
      cur_src  <= cur_osc.pll ? csw_pkg::SRC_FRC_PLL
                                       : csw_pkg::SRC_FRC;
    end else begin
      if (lo_ok && wr_data[csw_pkg::SWREQ_BIT] && sw_en && !sw_blocked) begin
        sw_req <= 1'b1;
      end
      unique case (sw_state)
        csw_pkg::SW_IDLE: begin
          if (sw_req && new_src == cur_src) begin
            sw_req <= 1'b0;
          end else if (sw_start) begin
            tgt_src  <= new_src;
            sw_state <= csw_pkg::SW_WAIT;
          end
        end
        csw_pkg::SW_WAIT: begin
          if (cnt_start) begin
            sw_state <= csw_pkg::SW_COUNT;
          end
        end
        csw_pkg::SW_COUNT: begin
          if (cnt_done) begin
            cur_src  <= tgt_src;
            sw_req   <= 1'b0;
            sw_state <= csw_pkg::SW_IDLE;
          end
        end
      endcase
    end
  end

  assign sys_sel = cur_src;

  // ****************************************
  // status bits and failure trap
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cf            <= 1'b0;
      pll_lock_st   <= 1'b0;
      clk_fail_trap <= 1'b0;
    end else begin
      clk_fail_trap <= fail_evt;
      if (fail_evt) begin
        cf <= 1'b1;
      end else if (sw_start || (lo_ok && !wr_data[csw_pkg::CF_BIT])) begin
        cf <= 1'b0;
      end
      if (sw_start) begin
        pll_lock_st <= 1'b0;
      end else begin
        pll_lock_st <= pll_locked && osc_en.pll;
      end
    end
  end

  // ****************************************
  // oscillator enables
  // ****************************************
  always_comb begin
    next_osc_en = '0;
    if (!strap_done) begin
      next_osc_en = '0;
    end else if (pm_state == csw_pkg::PM_SLEEP) begin
      next_osc_en.low_power_rc_osc = wdt_en;
    end else begin
      next_osc_en = src_osc(cur_src);
      if (sw_state != csw_pkg::SW_IDLE) begin
        next_osc_en = next_osc_en | src_osc(tgt_src);
      end
      // old source drops once cur_src moves on
      next_osc_en.low_power_rc_osc = next_osc_en.low_power_rc_osc || wdt_en || fsm_en;
      next_osc_en.sec  = next_osc_en.sec || sec_en;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_en <= '0;
    end else begin
      osc_en <= next_osc_en;
    end
  end

  // ****************************************
  // power-save modes
  // ****************************************
  assign wake_evt = wake_irq || wdt_timeout;

  csw_tick_cnt #(
    .W (csw_pkg::CNT_W),
    .N (csw_pkg::RESUME_CYC)
  ) u_resume_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (wake_evt && (sleep_mode || idle_mode)),
    .tick    (1'b1),
    .busy    (),
    .done    (res_done)
  );

  // an interrupt coinciding with entry is only seen once halted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pm_state      <= csw_pkg::PM_RUN;
      cpu_halt      <= 1'b0;
      periph_clk_en <= 1'b1;
      wdt_clear     <= 1'b0;
      sleep_mode    <= 1'b0;
      idle_mode     <= 1'b0;
    end else begin
      wdt_clear <= 1'b0;
      unique case (pm_state)
        csw_pkg::PM_RUN: begin
          if (psv_req) begin
            cpu_halt <= 1'b1;
            if (psv_mode == csw_pkg::PSV_SLEEP) begin
              pm_state      <= csw_pkg::PM_SLEEP;
              sleep_mode    <= 1'b1;
              periph_clk_en <= 1'b0;
              wdt_clear     <= wdt_en;
            end else begin
              pm_state  <= csw_pkg::PM_IDLE;
              idle_mode <= 1'b1;
              wdt_clear <= 1'b1;
            end
          end
        end
        csw_pkg::PM_SLEEP, csw_pkg::PM_IDLE: begin
          if (wake_evt) begin
            // cur_src is kept, so the same source comes back
            pm_state      <= csw_pkg::PM_RESUME;
            sleep_mode    <= 1'b0;
            idle_mode     <= 1'b0;
            periph_clk_en <= 1'b1;
          end
        end
        csw_pkg::PM_RESUME: begin
          if (res_done) begin
            pm_state <= csw_pkg::PM_RUN;
            cpu_halt <= 1'b0;
          end
        end
      endcase
    end
  end

endmodule

// File: logic/csw_pkg.sv
package csw_pkg;

  // ****************************************
  // register bus
  // ****************************************
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  OSC_CTRL_ADDR = 4'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ****************************************
  // oscillator control field positions
  // ****************************************
  localparam int CUR_LSB   = 12;
  localparam int NEW_LSB   = 8;
  localparam int LOCK_BIT  = 7;
  localparam int PLL_BIT   = 5;
  localparam int CF_BIT    = 3;
  localparam int SEC_BIT   = 1;
  localparam int SWREQ_BIT = 0;

  // ****************************************
  // source codes
  // ****************************************
  localparam logic [2:0] SRC_FRC      = 3'h0;
  localparam logic [2:0] SRC_FRC_PLL  = 3'h1;
  localparam logic [2:0] SRC_PRI      = 3'h2;
  localparam logic [2:0] SRC_PRI_PLL  = 3'h3;
  localparam logic [2:0] SRC_SEC      = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER_RC_OSC     = 3'h5;
  localparam logic [2:0] SRC_FRC_D16  = 3'h6;
  localparam logic [2:0] SRC_FRC_DIVN = 3'h7;

  // ****************************************
  // configuration codes
  // ****************************************
  localparam logic [1:0] CKSM_ALL     = 2'h0;
  localparam logic [1:0] CKSM_SW_ONLY = 2'h1;
  localparam logic [1:0] SUB_EC       = 2'h0;
  localparam logic [1:0] SUB_XT       = 2'h1;
  localparam logic [1:0] SUB_HS       = 2'h2;
  localparam logic       PSV_SLEEP    = 1'b0;
  localparam logic       PSV_IDLE     = 1'b1;

  // ****************************************
  // timing counts
  // ****************************************
  localparam int CNT_W        = 4;
  localparam int NEW_CLK_WAIT = 10;
  localparam int RESUME_CYC   = 2;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [1:0] switch_mode_cfg_field;
    logic [2:0] poweron_source_cfg;
    logic [1:0] primary_submode_cfg;
  } csw_cfg_t;

  typedef struct packed {
    logic fast_rc_osc;
    logic pri;
    logic sec;
    logic low_power_rc_osc;
    logic pll;
  } csw_osc_en_t;

  typedef enum logic [1:0] {SW_IDLE, SW_WAIT, SW_COUNT} csw_sw_state_t;
  typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_IDLE, PM_RESUME}
    csw_pm_state_t;

endpackage

// File: logic/csw_tick_cnt.sv
`timescale 1ns/100ps
module csw_tick_cnt #(
  parameter int W = 4,
  parameter int N = 10
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // control
  input  wire logic start,
  input  wire logic tick,
  output logic      busy,
  output logic      done
);

  logic [W-1:0] cnt;

  // ****************************************
  // down counter, one pulse after n ticks
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt  <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        cnt  <= W'(N);
      end else if (busy && tick) begin
        if (cnt == W'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        cnt <= cnt - W'(1);
      end
    end
  end

endmodule
